/* File: rtl/mvrx_pkg.sv */
// Purpose: shared constants for the move and return execution block
// Assumes: 8-bit data, 10-bit program counter, 14-bit instruction word
// Notes:   opcode encodings are local choices, not a binary-compatible map
package mvrx_pkg;
   // =====================================================
   // widths
   localparam int DATA_W  = 8;
   localparam int PC_W    = 10;
   localparam int FADDR_W = 6;
   localparam int INSTR_W = 14;
   localparam int SP_W    = 3;

   // =====================================================
   // instruction fields
   localparam int OP_HI   = 13;
   localparam int OP_LO   = 8;
   localparam int DEST_BIT = 7;

   // =====================================================
   // opcodes held in instr[13:8]
   localparam logic [5:0] OP_NOP      = 6'h00;
   localparam logic [5:0] OP_RET      = 6'h01;
   localparam logic [5:0] OP_RETURN_FROM_INTERRUPT    = 6'h02;
   localparam logic [5:0] OP_RETLIT   = 6'h03;
   localparam logic [5:0] OP_COPYACC  = 6'h04;
   localparam logic [5:0] OP_MOVFILE  = 6'h05;

   // =====================================================
   // reset values and step sizes
   localparam logic [7:0] ACC_RST  = 8'h00;
   localparam logic [9:0] PC_RST   = 10'h000;
   localparam logic [2:0] SP_RST   = 3'h0;
   localparam logic [9:0] PC_STEP  = 10'h001;
   localparam logic [2:0] SP_STEP  = 3'h1;

   typedef enum logic [0:0] {
      MVRX_EXEC  = 1'b0,
      MVRX_FLUSH = 1'b1
   } mvrx_state_t;
endpackage

/* File: rtl/mvrx_stack.sv */
// Purpose: return address stack of the core
// Assumes: pushes come from call logic outside this block
// Notes:   pop reads the top entry and moves the pointer down in the same edge
`timescale 1ns/10ps
`default_nettype none
module mvrx_stack
   import mvrx_pkg::*;
#(
   parameter int DEPTH = 8
) (
   input  wire logic            clk,      // core clock
   input  wire logic            rst,      // sync reset, high
   input  wire logic            push,     // push request
   input  wire logic [PC_W-1:0] push_pc,  // address pushed
   input  wire logic            pop,      // pop request
   output logic      [PC_W-1:0] top_pc,   // current top entry
   output logic      [SP_W-1:0] level     // stack level
);
   logic [PC_W-1:0] mem [DEPTH];
   logic [SP_W-1:0] sp_q;
   logic [SP_W-1:0] sp_d;
   logic [SP_W-1:0] top_idx;

   // =====================================================
   // pointer
   assign top_idx = SP_W'(sp_q - SP_STEP);
   assign top_pc  = mem[top_idx];
   assign level   = sp_q;
   // underflow wraps; software must not return more than it called
   assign sp_d = push ? SP_W'(sp_q + SP_STEP) : (pop ? top_idx : sp_q);

   always_ff @(posedge clk) begin
      if (rst) begin
         sp_q <= SP_RST;
      end else begin
         sp_q <= sp_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[sp_q] <= push_pc;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/mvrx_exec.sv */
// Purpose: executes register moves, no-operation and the three returns
// Assumes: file register read data is combinational from FILE_ADDR
// Notes:   one instruction offered per cycle on INSTR with INSTR_VALID
//
// Behaviour
// (RULE_01) copy accumulator into file register, flags untouched
// (RULE_02) move file to accumulator or back
// (RULE_03) move file sets zero flag from value
// (RULE_04) no-operation only advances program counter
// (RULE_05) literal return loads accumulator, pc, sets enable
// (RULE_06) literal return pops stack after using top
// (RULE_07) interrupt return pops pc, sets enable
// (RULE_08) subroutine return pops pc, enable untouched
// (RULE_09) returns discard fetched word, refetch at target
`timescale 1ns/10ps
`default_nettype none
module mvrx_exec
   import mvrx_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input  wire logic               CORE_CLK,     // 25 MHz core clock
   input  wire logic               SYS_RST,      // sync reset, high
   input  wire logic [INSTR_W-1:0] INSTR,        // fetched instruction
   input  wire logic               INSTR_VALID,  // instruction present
   input  wire logic [DATA_W-1:0]  FILE_RDATA,   // file register read data
   input  wire logic               PUSH,         // call logic push
   input  wire logic [PC_W-1:0]    PUSH_PC,      // pushed return address
   output logic      [FADDR_W-1:0] FILE_ADDR,    // file register select
   output logic      [DATA_W-1:0]  FILE_WDATA,   // file register write data
   output logic                    FILE_WE,      // file register write pulse
   output logic      [DATA_W-1:0]  ACCUMULATOR,  // accumulator
   output logic                    ZERO_FLAG,    // zero status flag
   output logic                    GLOBAL_INTERRUPT_ENABLE, // interrupt enable
   output logic      [PC_W-1:0]    PC,           // program counter
   output logic                    FETCH_DISCARD,// fetched word dropped
   output logic      [SP_W-1:0]    STACK_LEVEL   // stack level
);
   mvrx_state_t        state_q;
   mvrx_state_t        state_d;
   logic [DATA_W-1:0]  acc_q;
   logic [DATA_W-1:0]  acc_d;
   logic               zf_q;
   logic               zf_d;
   logic               gie_q;
   logic               gie_d;
   logic [PC_W-1:0]    pc_q;
   logic [PC_W-1:0]    pc_d;
   logic [PC_W-1:0]    pc_step;
   logic [DATA_W-1:0]  fwdata_q;
   logic [DATA_W-1:0]  fwdata_d;
   logic               fwe_q;
   logic               fwe_d;
   logic               disc_q;
   logic [SP_W-1:0]    lvl_q;
   logic [PC_W-1:0]    top_pc;
   logic [SP_W-1:0]    level;

   // =====================================================
   // decode
   // opcode match, closed while the flush cycle runs
   function automatic logic op_hit(input logic       taken,
                                   input logic [5:0] code,
                                   input logic [5:0] want);
      return taken && (code == want);
   endfunction

   wire [5:0]         opcode   = INSTR[OP_HI:OP_LO];
   wire               dest_f   = INSTR[DEST_BIT];
   wire [FADDR_W-1:0] faddr    = INSTR[FADDR_W-1:0];
   wire [DATA_W-1:0]  literal  = INSTR[DATA_W-1:0];
   wire               exec     = INSTR_VALID && (state_q == MVRX_EXEC);
   wire               is_copy  = op_hit(exec, opcode, OP_COPYACC);
   wire               is_move  = op_hit(exec, opcode, OP_MOVFILE);
   wire               is_rlit  = op_hit(exec, opcode, OP_RETLIT);
   wire               is_rie   = op_hit(exec, opcode, OP_RETURN_FROM_INTERRUPT);
   wire               is_ret   = op_hit(exec, opcode, OP_RET);
   wire               is_retx  = is_rlit || is_rie || is_ret;
   wire               ld_acc   = is_move && !dest_f;
   wire               wr_back  = is_move && dest_f;
   wire               do_pop   = is_retx; // RULE_06 RULE_07 RULE_08

   // =====================================================
   // next state
   // a return overrides the step; the flush cycle holds the pc still
   assign pc_step  = PC_W'(pc_q + PC_STEP); // RULE_04
   assign pc_d     = is_retx ? top_pc : (exec ? pc_step : pc_q); // RULE_05 RULE_07 RULE_08
   assign state_d  = is_retx ? MVRX_FLUSH : MVRX_EXEC; // RULE_09
   assign acc_d    = is_rlit ? literal : (ld_acc ? FILE_RDATA : acc_q); // RULE_02 RULE_05
   assign zf_d     = is_move ? (FILE_RDATA == '0) : zf_q; // RULE_03
   // only the two re-enabling returns touch the enable
   assign gie_d    = gie_q || is_rlit || is_rie; // RULE_05 RULE_07
   assign fwe_d    = is_copy || wr_back; // RULE_01 RULE_02
   assign fwdata_d = is_copy ? acc_q : (wr_back ? FILE_RDATA : fwdata_q); // RULE_01 RULE_02

   // =====================================================
   // registers
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         state_q <= MVRX_EXEC;
      end else begin
         state_q <= state_d;
      end
   end

   // marks the flush cycle; the word offered then is dropped
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         disc_q <= 1'b0;
      end else begin
         disc_q <= is_retx; // RULE_09
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         acc_q <= ACC_RST;
      end else begin
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         zf_q <= 1'b0;
      end else begin
         zf_q <= zf_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         gie_q <= 1'b0;
      end else begin
         gie_q <= gie_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         pc_q <= PC_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   // level shown one cycle behind the pointer
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         lvl_q <= SP_RST;
      end else begin
         lvl_q <= level;
      end
   end

   // write lands one edge late; the file side must hold the taken address
   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         fwdata_q <= ACC_RST;
      end else begin
         fwdata_q <= fwdata_d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) begin
         fwe_q <= 1'b0;
      end else begin
         fwe_q <= fwe_d;
      end
   end

   // =====================================================
   // stack
   mvrx_stack #(
      .DEPTH (STACK_DEPTH)
   ) u_stack (
      .clk     (CORE_CLK),
      .rst     (SYS_RST),
      .push    (PUSH),
      .push_pc (PUSH_PC),
      .pop     (do_pop),
      .top_pc  (top_pc),
      .level   (level)
   );

   // =====================================================
   // outputs; file address is combinational for the read path only
   always_comb FILE_ADDR = faddr;
   assign FILE_WDATA              = fwdata_q;
   assign FILE_WE                 = fwe_q;
   assign ACCUMULATOR             = acc_q;
   assign ZERO_FLAG               = zf_q;
   assign GLOBAL_INTERRUPT_ENABLE = gie_q;
   assign PC                      = pc_q;
   assign FETCH_DISCARD           = disc_q;
   assign STACK_LEVEL             = lvl_q;
endmodule
`default_nettype wire

/* File: tb/mvrx_props.sv */
// Purpose: port checks for mvrx_exec
// Assumes: one clock, sync reset
// Notes:   result lands one edge after the take
`timescale 1ns/10ps
`default_nettype none
module mvrx_props
   import mvrx_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input wire logic               CORE_CLK,    // clock
   input wire logic               SYS_RST,     // reset
   input wire logic [INSTR_W-1:0] INSTR,       // word
   input wire logic               INSTR_VALID, // valid
   input wire logic [DATA_W-1:0]  FILE_RDATA,  // read
   input wire logic [DATA_W-1:0]  FILE_WDATA,  // write
   input wire logic               FILE_WE,     // strobe
   input wire logic [DATA_W-1:0]  ACCUMULATOR, // acc
   input wire logic               ZERO_FLAG,   // zero
   input wire logic               GLOBAL_INTERRUPT_ENABLE, // enable
   input wire logic [PC_W-1:0]    PC,          // pc
   input wire logic               FETCH_DISCARD // flush
);
   // ==========
   // flush cycle words are never taken
   wire [5:0] op   = INSTR[OP_HI:OP_LO];
   wire [7:0] lit  = INSTR[7:0];
   wire       take = INSTR_VALID && !FETCH_DISCARD;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   chk_copy_write: assert property (take && op == OP_COPYACC |=> FILE_WE
      && FILE_WDATA == $past(ACCUMULATOR) && $stable(ZERO_FLAG)) else $error("copy bad");
   chk_move_acc: assert property (take && op == OP_MOVFILE && !INSTR[DEST_BIT]
      |=> ACCUMULATOR == $past(FILE_RDATA) && !FILE_WE) else $error("move acc bad");
   chk_move_back: assert property (take && op == OP_MOVFILE && INSTR[DEST_BIT]
      |=> FILE_WE && FILE_WDATA == $past(FILE_RDATA)
      && $stable(ACCUMULATOR)) else $error("move r bad");
   chk_zero_flag: assert property (take && op == OP_MOVFILE
      |=> ZERO_FLAG == ($past(FILE_RDATA) == 8'h00)) else $error("zero bad");
   chk_nop_step: assert property (take && op == OP_NOP |=> PC == $past(PC) + PC_STEP
      && $stable(ACCUMULATOR) && $stable(ZERO_FLAG) && !FILE_WE) else $error("nop bad");
   chk_retlit_load: assert property (take && op == OP_RETLIT |=> FETCH_DISCARD
      && ACCUMULATOR == $past(lit) && GLOBAL_INTERRUPT_ENABLE) else $error("retlit bad");
   chk_return_from_interrupt_gie: assert property (take && op == OP_RETURN_FROM_INTERRUPT |=> FETCH_DISCARD ##1
      GLOBAL_INTERRUPT_ENABLE && !FETCH_DISCARD) else $error("return_from_interrupt bad");
   chk_ret_keep: assert property (take && op == OP_RET |=> FETCH_DISCARD
      && $stable(GLOBAL_INTERRUPT_ENABLE) && $stable(ACCUMULATOR)) else $error("ret bad");
   chk_flush_hold: assert property (FETCH_DISCARD |=> $stable(PC) && !FILE_WE)
      else $error("flush bad");
endmodule
bind mvrx_exec mvrx_props #(
   .STACK_DEPTH (STACK_DEPTH)
) u_props (
   .CORE_CLK                (CORE_CLK),
   .SYS_RST                 (SYS_RST),
   .INSTR                   (INSTR),
   .INSTR_VALID             (INSTR_VALID),
   .FILE_RDATA              (FILE_RDATA),
   .FILE_WDATA              (FILE_WDATA),
   .FILE_WE                 (FILE_WE),
   .ACCUMULATOR             (ACCUMULATOR),
   .ZERO_FLAG               (ZERO_FLAG),
   .GLOBAL_INTERRUPT_ENABLE (GLOBAL_INTERRUPT_ENABLE),
   .PC                      (PC),
   .FETCH_DISCARD           (FETCH_DISCARD)
);
`default_nettype wire

/* File: tb/test_mvrx_exec.sv */
// Purpose: directed test of mvrx_exec
// Assumes: bench models the file registers
// Notes:   instructions are spaced one idle edge apart
`timescale 1ns/10ps
`default_nettype none
module test_mvrx_exec import mvrx_pkg::*;;
   logic        CORE_CLK = 1'h0, SYS_RST = 1'h1, INSTR_VALID = 1'h0, PUSH = 1'h0;
   logic [13:0] INSTR = 14'h0000;
   logic [9:0]  PUSH_PC = 10'h000, PC, p;
   logic [7:0]  FILE_RDATA, FILE_WDATA, ACCUMULATOR, mem [64];
   logic [5:0]  FILE_ADDR, addr_q;
   logic        FILE_WE, ZERO_FLAG, GLOBAL_INTERRUPT_ENABLE, FETCH_DISCARD;
   logic [2:0]  STACK_LEVEL;
   int          n_errors = 0, comparisons = 0, cyc = 0;
   mvrx_exec u_dut (
      .CORE_CLK                (CORE_CLK),
      .SYS_RST                 (SYS_RST),
      .INSTR                   (INSTR),
      .INSTR_VALID             (INSTR_VALID),
      .FILE_RDATA              (FILE_RDATA),
      .PUSH                    (PUSH),
      .PUSH_PC                 (PUSH_PC),
      .FILE_ADDR               (FILE_ADDR),
      .FILE_WDATA              (FILE_WDATA),
      .FILE_WE                 (FILE_WE),
      .ACCUMULATOR             (ACCUMULATOR),
      .ZERO_FLAG               (ZERO_FLAG),
      .GLOBAL_INTERRUPT_ENABLE (GLOBAL_INTERRUPT_ENABLE),
      .PC                      (PC),
      .FETCH_DISCARD           (FETCH_DISCARD),
      .STACK_LEVEL             (STACK_LEVEL)
   );
   assign FILE_RDATA = mem[FILE_ADDR];
   initial forever #20 CORE_CLK = ~CORE_CLK;
   // ==========
   // file write lands one edge after the take
   always @(posedge CORE_CLK) begin
      addr_q <= FILE_ADDR;
      if (SYS_RST) begin
         foreach (mem[k]) mem[k] <= (k == 5) ? 8'ha5 : 8'h00;
      end else if (FILE_WE) begin
         mem[addr_q] <= FILE_WDATA;
      end
      cyc <= cyc + 1;
      if (cyc == 800) begin
         n_errors++;
         end_of_test();
      end
   end
   task cmp(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task exec(input logic [13:0] i);
      @(posedge CORE_CLK);
      INSTR <= i;
      INSTR_VALID <= 1'h1;
      @(posedge CORE_CLK);
      INSTR_VALID <= 1'h0;
      #1;
   endtask
   task push(input logic [9:0] a);
      @(posedge CORE_CLK);
      PUSH <= 1'h1;
      PUSH_PC <= a;
      @(posedge CORE_CLK);
      PUSH <= 1'h0;
   endtask
   // a word offered in the flush cycle must be dropped
   task ret(input logic [13:0] i, input logic [9:0] t, input logic [8:0] ag, input logic [2:0] lv);
      @(posedge CORE_CLK);
      INSTR <= i;
      INSTR_VALID <= 1'h1;
      @(posedge CORE_CLK);
      INSTR <= {OP_NOP, 8'h00};
      #1;
      cmp(20'({PC, FETCH_DISCARD}), 20'({t, 1'h1}));
      cmp(20'({ACCUMULATOR, GLOBAL_INTERRUPT_ENABLE}), 20'(ag));
      @(posedge CORE_CLK);
      INSTR_VALID <= 1'h0;
      @(posedge CORE_CLK);
      #1;
      cmp(20'({PC, STACK_LEVEL}), 20'({t, lv}));
   endtask
   // copy runs with the zero flag set, so a stray flag update shows
   task t_moves;
      exec({OP_MOVFILE, 8'h05});
      cmp(20'({ACCUMULATOR, ZERO_FLAG}), 20'h0014a);
      exec({OP_MOVFILE, 8'h80});
      cmp(20'({FILE_WE, FILE_WDATA, ZERO_FLAG, ACCUMULATOR}), 20'h201a5);
      exec({OP_COPYACC, 8'h3f});
      cmp(20'({FILE_WE, FILE_WDATA, ZERO_FLAG}), 20'h0034b);
      exec({OP_MOVFILE, 8'h00});
      cmp(20'({ACCUMULATOR, ZERO_FLAG}), 20'h00001);
      exec({OP_MOVFILE, 8'h3f});
      cmp(20'({ACCUMULATOR, ZERO_FLAG}), 20'h0014a);
   endtask
   task t_nop;
      p = PC;
      exec({OP_NOP, 8'h00});
      cmp(20'({PC, ACCUMULATOR, ZERO_FLAG, FILE_WE}),
          20'({p + PC_STEP, 8'ha5, 1'h0, 1'h0}));
   endtask
   task t_returns;
      push(10'h100);
      push(10'h2a5);
      push(10'h155);
      repeat (3) @(posedge CORE_CLK);
      ret({OP_RET, 8'h00}, 10'h155, 9'h14a, 3'h2);
      ret({OP_RETURN_FROM_INTERRUPT, 8'h00}, 10'h2a5, 9'h14b, 3'h1);
      ret({OP_RETLIT, 8'h55}, 10'h100, 9'h0ab, 3'h0);
   endtask
   task end_of_test;
      $display("n_errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge CORE_CLK);
      SYS_RST <= 1'h0;
      #1;
      cmp({ACCUMULATOR, ZERO_FLAG, GLOBAL_INTERRUPT_ENABLE, PC}, 20'h0);
      t_moves();
      t_nop();
      t_returns();
      end_of_test();
   end
endmodule
`default_nettype wire
